// File: core/rms_pkg.sv
package rms_pkg;

  // mode-select data bit positions (default when high, alternate when low)
  localparam int BIT_BOOT_WIDTH = 0;
  localparam int BIT_CS_LOW     = 1;
  localparam int BIT_CS_MID     = 2;
  localparam int BIT_ADDR_FIRST = 3;
  localparam int BIT_ADDR_LAST  = 7;
  localparam int BIT_PORT_E     = 8;
  localparam int BIT_PORT_F     = 9;
  localparam int BIT_RESERVED   = 11;

  // widths
  localparam int DATA_W   = 16;
  localparam int ADDR_W   = 24;
  localparam int NUM_HIGH = 5;

  // cycles from reset release to first bus cycle
  localparam int FIRST_BUS_CYCLES = 10;
  localparam logic [3:0] FIRST_BUS_COUNT = 4'ha;
  // breakpoint low time before reset release, in clocks
  localparam int BREAK_HOLD_CYCLES = 2;

  // vector fetch start address
  localparam logic [23:0] VECTOR_BASE = 24'h000000;
  // supervisor program space function code
  localparam logic [2:0]  SUPER_PROG_FC = 3'h6;

  // sampled-defaults when lines float high
  localparam logic [15:0] DATA_DEFAULT = 16'hffff;

  typedef enum logic [1:0] {
    RMS_IN_RESET,
    RMS_WAIT_BUS,
    RMS_RUN
  } rms_phase_e;

endpackage

// File: core/rms_sync.sv
module rms_sync #(
  parameter int WIDTH = 1
) (
  // clock
  input  wire logic             i_clk,
  // asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1;

  // two-flop synchroniser; stage1 is seen only by o_sync
  // no reset: the straps must be sampled while reset is held
  always_ff @(posedge i_clk) begin
    stage1 <= i_async;
    o_sync <= stage1;
  end

endmodule

// File: core/rms_reset_mode_select.sv
module rms_reset_mode_select (
  // clock and reset
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RESETN,
  // mode-select pins, asynchronous
  input  wire logic [15:0] I_DATA_PIN,
  input  wire logic        I_CLOCK_MODE_PIN,
  input  wire logic        I_BREAKPOINT_PIN_N,
  // later breakpoint sources
  input  wire logic        I_BREAKPOINT_INTERNAL,
  // data bus pin control
  output logic             O_DATA_PULLUP_EN,
  output logic             O_DATA_DRIVE_ALLOWED,
  output logic             O_FIRST_BUS_CYCLE,
  // boot chip-select and vector fetch
  output logic             O_BOOT_CHIP_SELECT_N,
  output logic             O_BOOT_PORT_16BIT,
  output logic             O_VECTOR_FETCH,
  output logic [23:0]      O_VECTOR_ADDR,
  output logic [2:0]       O_VECTOR_FC,
  // pin function selects, 1 = alternate function
  output logic             O_CS_LOW_ALT,
  output logic             O_CS_MID_ALT,
  output logic [4:0]       O_CS_HIGH_ADDR,
  output logic             O_PORT_E_SEL,
  output logic             O_PORT_F_SEL,
  output logic             O_RESERVED_MODE,
  // clock source
  output logic             O_SYNTH_ENABLE,
  // debug
  output logic             O_BACKGROUND_DEBUG_ENABLE,
  output logic             O_ENTER_BACKGROUND_DEBUG,
  output logic             O_BREAKPOINT_EXCEPTION,
  // other modules' pin defaults
  output logic             O_MODULE_PIN_FUNC_EN,
  output logic             O_MODULE_PORT_DIR,
  output logic             O_PULSE_OUT_A_DISCRETE,
  output logic             O_PULSE_OUT_B_DISCRETE
);

  logic [15:0] data_sync;
  logic        clk_mode_sync;
  logic        breakpoint_pin_sync_n;
  logic [15:0] data_latch;
  logic        clk_mode_latch;
  logic        debug_en;
  logic        breakpoint_pin_prev_n;
  logic [3:0]  wait_cnt;
  logic [1:0]  low_cnt;
  logic        vector_active;
  rms_pkg::rms_phase_e phase;
  rms_pkg::rms_phase_e next_phase;

  // all pin levels are asynchronous; synchroniser keeps running in reset
  rms_sync #(
    .WIDTH (18)
  ) u_sync (
    .i_clk    (I_SYS_CLK),
    .i_async  ({I_CLOCK_MODE_PIN, I_BREAKPOINT_PIN_N, I_DATA_PIN}),
    .o_sync   ({clk_mode_sync, breakpoint_pin_sync_n, data_sync})
  );

  // phase sequencing: reset, wait for first bus cycle, run
  always_comb begin
    next_phase = phase;
    case (phase)
      rms_pkg::RMS_IN_RESET: next_phase = rms_pkg::RMS_WAIT_BUS;
      rms_pkg::RMS_WAIT_BUS: begin
        if (wait_cnt == rms_pkg::FIRST_BUS_COUNT - 4'h1) begin
          next_phase = rms_pkg::RMS_RUN;
        end
      end
      rms_pkg::RMS_RUN: next_phase = rms_pkg::RMS_RUN;
      default: next_phase = rms_pkg::RMS_IN_RESET;
    endcase
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      phase <= rms_pkg::RMS_IN_RESET;
    end else begin
      phase <= next_phase;
    end
  end

  // first bus cycle lands ten clocks after release
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      wait_cnt <= 4'h0;
    end else if (phase == rms_pkg::RMS_WAIT_BUS) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end

  // mode samples hold DATA_DEFAULT during reset, frozen afterwards;
  // a reset-time constant alone would lose the strap, so we capture
  // in the first clock after release from synced pin levels
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      data_latch     <= rms_pkg::DATA_DEFAULT;
      clk_mode_latch <= 1'h1;
    end else if (phase == rms_pkg::RMS_IN_RESET) begin
      data_latch     <= data_sync;
      clk_mode_latch <= clk_mode_sync;
    end
  end

  // count breakpoint low clocks seen while reset is still held
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESETN && phase != rms_pkg::RMS_IN_RESET) begin
      low_cnt <= low_cnt;
    end else if (breakpoint_pin_sync_n) begin
      low_cnt <= 2'h0;
    end else if (low_cnt != 2'h3) begin
      low_cnt <= low_cnt + 2'h1;
    end
  end

  // debug enable decided once per reset rising edge
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      debug_en <= 1'h0;
    end else if (phase == rms_pkg::RMS_IN_RESET) begin
      debug_en <= (low_cnt >= 2'(rms_pkg::BREAK_HOLD_CYCLES));
    end
  end // held until next reset

  // breakpoint edge detect, only after the first bus cycle
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      breakpoint_pin_prev_n <= 1'h1;
    end else begin
      breakpoint_pin_prev_n <= breakpoint_pin_sync_n;
    end
  end

  // vector fetch flag runs from release to first bus cycle
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      vector_active <= 1'h0;
    end else begin
      vector_active <= (next_phase == rms_pkg::RMS_WAIT_BUS);
    end
  end

  // data pins: pulled up throughout, driven only after first cycle
  assign O_DATA_PULLUP_EN     = 1'h1;
  assign O_DATA_DRIVE_ALLOWED = (phase == rms_pkg::RMS_RUN);
  assign O_FIRST_BUS_CYCLE    = (phase == rms_pkg::RMS_WAIT_BUS) &&
                                (wait_cnt == rms_pkg::FIRST_BUS_COUNT - 4'h1);

  // boot select low as soon as reset lets go, unlike other selects
  assign O_BOOT_CHIP_SELECT_N = !I_RESETN;
  assign O_BOOT_PORT_16BIT    = data_latch[rms_pkg::BIT_BOOT_WIDTH];
  assign O_VECTOR_FETCH       = vector_active;
  assign O_VECTOR_ADDR        = rms_pkg::VECTOR_BASE;
  assign O_VECTOR_FC          = rms_pkg::SUPER_PROG_FC;

  // chip-select group functions, low level picks alternate
  assign O_CS_LOW_ALT = !data_latch[rms_pkg::BIT_CS_LOW];
  assign O_CS_MID_ALT = !data_latch[rms_pkg::BIT_CS_MID];

  // a low bit switches its select and all lower down to select six
  genvar g;
  generate
    for (g = 0; g < rms_pkg::NUM_HIGH; g++) begin : g_addr
      assign O_CS_HIGH_ADDR[g] =
        ~&data_latch[rms_pkg::BIT_ADDR_LAST:rms_pkg::BIT_ADDR_FIRST + g];
    end
  endgenerate

  assign O_PORT_E_SEL    = !data_latch[rms_pkg::BIT_PORT_E];
  assign O_PORT_F_SEL    = !data_latch[rms_pkg::BIT_PORT_F];
  // flagged only; low bit 11 is a board fault, not a mode we support
  assign O_RESERVED_MODE = !data_latch[rms_pkg::BIT_RESERVED];
  assign O_SYNTH_ENABLE  = clk_mode_latch;

  // breakpoint routing; tagging of the first cycle is the board's worry
  assign O_BACKGROUND_DEBUG_ENABLE = debug_en;
  assign O_ENTER_BACKGROUND_DEBUG  = debug_en && (phase == rms_pkg::RMS_RUN) &&
    ((breakpoint_pin_prev_n && !breakpoint_pin_sync_n) || I_BREAKPOINT_INTERNAL);
  assign O_BREAKPOINT_EXCEPTION    = !debug_en && (phase == rms_pkg::RMS_RUN) &&
    ((breakpoint_pin_prev_n && !breakpoint_pin_sync_n) || I_BREAKPOINT_INTERNAL);

  // module pins come up as port inputs; pulse outputs stay outputs
  assign O_MODULE_PIN_FUNC_EN   = 1'h0;
  assign O_MODULE_PORT_DIR      = 1'h0;
  assign O_PULSE_OUT_A_DISCRETE = 1'h1;
  assign O_PULSE_OUT_B_DISCRETE = 1'h1;

endmodule

// File: testbench/rms_reset_mode_select_checker.sv
module rms_reset_mode_select_checker (
  // clock, reset and pins
  input wire logic        I_SYS_CLK,
  input wire logic        I_RESETN,
  input wire logic [15:0] I_DATA_PIN,
  input wire logic        I_BREAKPOINT_PIN_N,
  input wire logic        I_BREAKPOINT_INTERNAL,
  // watched outputs
  input wire logic        O_DATA_DRIVE_ALLOWED,
  input wire logic        O_FIRST_BUS_CYCLE,
  input wire logic        O_BOOT_CHIP_SELECT_N,
  input wire logic        O_BOOT_PORT_16BIT,
  input wire logic        O_VECTOR_FETCH,
  input wire logic [23:0] O_VECTOR_ADDR,
  input wire logic [2:0]  O_VECTOR_FC,
  input wire logic        O_SYNTH_ENABLE,
  input wire logic        O_BACKGROUND_DEBUG_ENABLE,
  input wire logic        O_ENTER_BACKGROUND_DEBUG,
  input wire logic        O_BREAKPOINT_EXCEPTION
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       held_w;
  logic [1:0] held_bk;
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESETN);
  // shadow taken in reset only, as the pins are freed soon after release
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      held_w  <= I_DATA_PIN[0];
      held_bk <= {held_bk[0], I_BREAKPOINT_PIN_N};
    end
  end
  a_boot_cs_live: assert property (I_RESETN |-> !O_BOOT_CHIP_SELECT_N)
    else $error("boot select idle");
  a_first_bus_ten: assert property ($rose(I_RESETN) |-> ##10 O_FIRST_BUS_CYCLE)
    else $error("first bus cycle late");
  a_drive_after_bus: assert property (
    O_FIRST_BUS_CYCLE |-> !O_DATA_DRIVE_ALLOWED ##1 O_DATA_DRIVE_ALLOWED)
    else $error("data drive timing");
  a_vector_start: assert property ($rose(I_RESETN) |=> O_VECTOR_FETCH &&
    O_VECTOR_ADDR == 24'h000000 && O_VECTOR_FC == 3'h6)
    else $error("vector fetch wrong");
  a_boot_width: assert property ($rose(I_RESETN) |=> O_BOOT_PORT_16BIT == held_w)
    else $error("boot width wrong");
  a_debug_select: assert property (
    $rose(I_RESETN) |=> O_BACKGROUND_DEBUG_ENABLE == (held_bk == 2'h0))
    else $error("debug enable wrong");
  a_config_held: assert property ($past(I_RESETN) |=>
    $stable({O_BOOT_PORT_16BIT, O_SYNTH_ENABLE, O_BACKGROUND_DEBUG_ENABLE}))
    else $error("config moved");
  a_break_route: assert property (
    O_DATA_DRIVE_ALLOWED && I_BREAKPOINT_INTERNAL |-> O_ENTER_BACKGROUND_DEBUG ==
    O_BACKGROUND_DEBUG_ENABLE && O_BREAKPOINT_EXCEPTION == !O_BACKGROUND_DEBUG_ENABLE)
    else $error("breakpoint routed wrong");
endmodule
bind rms_reset_mode_select rms_reset_mode_select_checker u_rms_reset_mode_select_checker (.*);

// File: testbench/rms_mode_driver.sv
module rms_mode_driver (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // levels forced while reset is held
  input  wire logic [15:0] i_mode,
  input  wire logic        i_clock_mode,
  input  wire logic        i_debug_req,
  // breakpoint asserted after the pins were freed
  input  wire logic        i_late_break,
  // pins toward the block
  output logic      [15:0] o_data_pin,
  output logic             o_clock_mode_pin,
  output logic             o_breakpoint_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] hold;
  logic       drive;
  // keep forcing a few clocks past release, well inside the ten-cycle gap
  always_ff @(posedge i_clk) begin
    if (!i_resetn) hold <= 2'h3;
    else if (hold != 2'h0) hold <= hold - 2'h1;
  end
  // no bus cycle runs while reset is held here, so strobe gating is moot
  assign drive = !i_resetn || (hold != 2'h0);
  // freed lines: pull-ups on data and breakpoint, clock-mode shows the inverse
  assign o_data_pin = drive ? i_mode : 16'hffff;
  assign o_clock_mode_pin = drive ? i_clock_mode : !i_clock_mode;
  assign o_breakpoint_pin_n = drive ? !i_debug_req : !i_late_break;
endmodule

// File: testbench/rms_reset_mode_select_tb.sv
module rms_reset_mode_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
  int errors = 0;
  int num_checks = 0;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        clkm = 1'b1;
  logic        dreq = 1'b0;
  logic        ibp = 1'b0;
  logic        lbk = 1'b0;
  logic [15:0] mode = 16'hffff;
  logic [15:0] data;
  logic        clkpin, bkpin, pull, drive, first, boot_n, w16, lo, mid, pe, pf, rsv, syn;
  logic        dbg, enter, exc, fen, dir, pa, pb;
  logic [4:0]  hi;
  initial forever #4 clk = ~clk;
  rms_mode_driver u_rms_mode_driver (.i_clk(clk), .i_resetn(resetn), .i_mode(mode),
    .i_clock_mode(clkm), .i_debug_req(dreq), .i_late_break(lbk), .o_data_pin(data),
    .o_clock_mode_pin(clkpin), .o_breakpoint_pin_n(bkpin));
  rms_reset_mode_select u_rms_reset_mode_select (.I_SYS_CLK(clk), .I_RESETN(resetn),
    .I_DATA_PIN(data), .I_CLOCK_MODE_PIN(clkpin), .I_BREAKPOINT_PIN_N(bkpin),
    .I_BREAKPOINT_INTERNAL(ibp), .O_DATA_PULLUP_EN(pull), .O_DATA_DRIVE_ALLOWED(drive),
    .O_FIRST_BUS_CYCLE(first), .O_BOOT_CHIP_SELECT_N(boot_n), .O_BOOT_PORT_16BIT(w16),
    .O_VECTOR_FETCH(), .O_VECTOR_ADDR(), .O_VECTOR_FC(), .O_CS_LOW_ALT(lo),
    .O_CS_MID_ALT(mid), .O_CS_HIGH_ADDR(hi), .O_PORT_E_SEL(pe), .O_PORT_F_SEL(pf),
    .O_RESERVED_MODE(rsv), .O_SYNTH_ENABLE(syn), .O_BACKGROUND_DEBUG_ENABLE(dbg),
    .O_ENTER_BACKGROUND_DEBUG(enter), .O_BREAKPOINT_EXCEPTION(exc),
    .O_MODULE_PIN_FUNC_EN(fen), .O_MODULE_PORT_DIR(dir),
    .O_PULSE_OUT_A_DISCRETE(pa), .O_PULSE_OUT_B_DISCRETE(pb));
  // reset with given levels, then follow release to the first bus cycle
  task automatic boot(input logic [15:0] m, input logic c, input logic d);
    int k;
    @(negedge clk);
    mode = m;
    clkm = c;
    dreq = d;
    resetn = 1'b0;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (first !== 1'b1 && k < 20);
    `CHK("bus start", rms_pkg::FIRST_BUS_CYCLES, k)
    `CHK("early drive", 1'b0, drive)
    `CHK("boot select", 1'b0, boot_n)
    @(negedge clk);
    `CHK("late drive", 1'b1, drive)
  endtask
  // selects after the pins were freed, then one internal breakpoint
  task automatic check_cfg(input logic [15:0] m, input logic c, input logic d);
    logic [4:0]  h;
    logic [12:0] e;
    h = 5'h00;
    for (int j = 3; j < 8; j++) if (!m[j]) h = h | ((5'h01 << (j - 2)) - 5'h01);
    e = {m[0], ~m[2:1], h, ~m[9:8], ~m[11], c, d};
    `CHK("config", e, {w16, mid, lo, hi, pf, pe, rsv, syn, dbg})
    ibp = 1'b1;
    #1;
    `CHK("break route", {d, !d}, {enter, exc})
    @(negedge clk);
    ibp = 1'b0;
    // pin breakpoint: one low clock, edge seen after the synchroniser
    lbk = 1'b1;
    @(negedge clk);
    lbk = 1'b0;
    @(negedge clk);
    `CHK("pin break route", {d, !d}, {enter, exc})
  endtask
  // every alternate selection at once, debug on
  task automatic t_alternate();
    boot(16'hfc00, 1'b0, 1'b1);
    check_cfg(16'hfc00, 1'b0, 1'b1);
  endtask
  // second reset with floating pins must drop debug again
  task automatic t_defaults();
    boot(16'hffff, 1'b1, 1'b0);
    check_cfg(16'hffff, 1'b1, 1'b0);
    `CHK("pin defaults", 5'h13, {pull, fen, dir, pa, pb})
  endtask
  // one address bit low at a time
  task automatic t_addr_map();
    for (int g = 3; g < 8; g++) begin
      boot(~(16'h0001 << g), 1'b1, 1'b0);
      check_cfg(~(16'h0001 << g), 1'b1, 1'b0);
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    t_alternate();
    t_defaults();
    t_addr_map();
    tally_and_finish();
  end
  // seven boots take about a hundred and forty clocks
  initial begin
    #20000;
    errors++;
    tally_and_finish();
  end
endmodule
